// ---- hdl/tdmtx_pkg.sv ----
`default_nettype none
package tdmtx_pkg;
	localparam int          CLK_KHZ      = 200000;
	localparam int          INT_OSC_KHZ  = 24704;
	localparam int          INT_DIV_CYC  = CLK_KHZ / INT_OSC_KHZ;
	localparam int          EXT_LOSS_NS  = 1000;
	localparam int          EXT_LOSS_CYC = EXT_LOSS_NS * CLK_KHZ / 1000000;
	localparam int          CLK_LOSS_NS  = 2000;
	localparam int          CLK_LOSS_CYC = CLK_LOSS_NS * CLK_KHZ / 1000000;
	localparam int          LOCK_US      = 10;
	localparam int          LOCK_CYC     = LOCK_US * CLK_KHZ / 1000;
	localparam int          DLY_BITS     = 16;
	localparam int          NUM_CH       = 24;
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_LIMIT   = 12'h004;
	localparam logic [11:0] ADDR_STAT    = 12'h008;
	localparam int          CTRL_MODE    = 0;
	localparam int          CTRL_BIPOLAR = 2;
	localparam int          CTRL_ZS      = 3;
	localparam int          CTRL_FULLALM = 4;
	localparam int          CTRL_LOOP    = 5;
	localparam int          CTRL_VARIANT = 6;
	localparam int          CTRL_TONE    = 7;
	localparam logic [7:0]  CTRL_RST     = 8'h03;
	localparam logic [15:0] LIMIT_RST    = 16'h0800;
	localparam logic [1:0]  MODE_24CH    = 2'h3;
	localparam logic [7:0]  ALARM_PAT    = 8'hf0;
	localparam logic [11:0] FRAME_PAT    = 12'h8dc;
	localparam logic [3:0]  FRAME_LEN    = 4'hc;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		SRC_INT  = 2'h0,
		SRC_LOCK = 2'h1,
		SRC_EXT  = 2'h3
	} tdmtx_src_t;

	function automatic logic [4:0] nchan(input logic [1:0] mode);
		case (mode)
			2'h0: nchan = 5'h03;
			2'h1: nchan = 5'h06;
			2'h2: nchan = 5'h0c;
			default: nchan = 5'h18;
		endcase
	endfunction : nchan

	function automatic logic [2:0] rate_mask(input logic [1:0] mode);
		case (mode)
			2'h0: rate_mask = 3'h7;
			2'h1: rate_mask = 3'h3;
			2'h2: rate_mask = 3'h1;
			default: rate_mask = 3'h0;
		endcase
	endfunction : rate_mask

	// Eight samples per tone cycle at the frame rate give the tone.
	function automatic logic [7:0] tone_word(input logic [2:0] idx);
		case (idx)
			3'h0: tone_word = 8'h80;
			3'h1: tone_word = 8'hda;
			3'h2: tone_word = 8'hff;
			3'h3: tone_word = 8'hda;
			3'h4: tone_word = 8'h80;
			3'h5: tone_word = 8'h25;
			3'h6: tone_word = 8'h00;
			default: tone_word = 8'h25;
		endcase
	endfunction : tone_word
endpackage : tdmtx_pkg
`default_nettype wire

// ---- hdl/tdmtx_dly_mem.sv ----
`default_nettype none
module tdmtx_dly_mem (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       we,
	input  wire logic [1:0] wdata,
	output logic      [1:0] rdata_q
);
	// The read register adds one bit time, so the ring is one short.
	localparam int DEPTH = tdmtx_pkg::DLY_BITS - 1;
	logic [1:0] mem [DEPTH];
	logic [3:0] ptr_q;

	always_ff @(posedge aclk)
	begin
		if (we)
		begin
			mem[ptr_q] <= wdata;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ptr_q   <= 4'h0;
			rdata_q <= 2'h0;
		end
		else if (we)
		begin
			rdata_q <= mem[ptr_q];
			ptr_q   <= (ptr_q == 4'(DEPTH - 1)) ? 4'h0 : ptr_q + 4'h1;
		end
	end
endmodule : tdmtx_dly_mem
`default_nettype wire

// ---- hdl/tdmtx_act_mon.sv ----
`default_nettype none
module tdmtx_act_mon (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        tick,
	input  wire logic        sig,
	input  wire logic [15:0] limit,
	output logic             lost_q
);
	logic [15:0] cnt_q;
	logic        last_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q  <= 16'h0000;
			last_q <= 1'b0;
			lost_q <= 1'b0;
		end
		else if (tick)
		begin
			last_q <= sig;
			if (sig != last_q)
			begin
				cnt_q  <= 16'h0000; // [R24]
				lost_q <= 1'b0;
			end
			else if (cnt_q >= limit)
			begin
				lost_q <= 1'b1; // [R24]
			end
			else
			begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule : tdmtx_act_mon
`default_nettype wire

// ---- hdl/tdmtx_mux.sv ----
// Notes on behaviour
// R1: Voice slots carry plain PCM, zero-suppressed PCM or the 1 kHz tone word.
// R2: Stream interleaves digital data, voice and framing bits by slot enables.
// R3: Data slot enable follows the data enable from the digital channel units.
// R4: Framing pattern runs on stream timing per mode; frame timing goes to PCM.
// R5: Loss of framing pattern, framing enable or stream data raises fault alarm.
// R6: Variant option forces bit 7 to one when voice bits 1 to 7 are zero.
// R7: Bit/channel counter on stream timing; channel count also goes to PCM.
// R8: Bit count, gated by channel count, sequences bits and drives wrap control.
// R9: One channel select line per channel module marks its transmit time.
// R10: Counter control reloads the start value so sequencing restarts at channel 1.
// R11: Mode field selects 3, 6, 12 or 24 channel sequencing.
// R12: External timing is used while active; internal source takes over on loss.
// R13: Source is divided and the rate matching the channel mode is chosen.
// R14: Zero suppression and full alarm select come from operator controls.
// R15: Divider, selector or power sync loop stopping raises loss of output.
// R16: Power sync pulse twice per frame, one aligned with the channel 1 restart.
// R17: Local loop replaces stream data with loopback data.
// R18: Line output is NRZ or bipolar by operator choice, timed by stream clock.
// R19: Outgoing stream clock or data stopping raises the output alarm.
// R20: Stream clock also leaves on NRZ clock and master clock outputs.
// R21: 24 channel bipolar: zero data channel and voice bits 1 to 6 zero set bit 7.
// R22: Digital data is delayed sixteen bit times before interleaving.
// R23: Outgoing alarm with full alarm selected replaces delayed data with pattern.
// R24: Activity loss after a set count without transitions; clears on resumption.
// R25: Bipolar marks ones with alternating pulses and zeros with no pulse.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module tdmtx_mux (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_clk,
	input  wire logic [7:0]  pcm_word,
	input  wire logic        dig_data,
	input  wire logic        data_enable,
	input  wire logic        alarm_in,
	input  wire logic        loop_data,
	output logic [23:0]      chan_sel_q,
	output logic [4:0]       chan_count_q,
	output logic             frame_sync_q,
	output logic             line_nrz_q,
	output logic             line_pos_q,
	output logic             line_neg_q,
	output logic             nrz_clk_q,
	output logic             master_clk_q,
	output logic             power_sync_q,
	output logic             fault_alarm_q,
	output logic             loss_output_q,
	output logic             out_alarm_q
);
	logic [7:0]  ctrl_q;
	logic [15:0] limit_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_full_q;
	logic        w_full_q;
	tdmtx_pkg::tdmtx_src_t src_q;
	logic [11:0] lock_q;
	logic [3:0]  int_cnt_q;
	logic        ext_d_q;
	logic [2:0]  div_q;
	logic        sclk_q;
	logic [2:0]  bit_q;
	logic [4:0]  chan_q;
	logic        fbit_q;
	logic [3:0]  fpos_q;
	logic [2:0]  tone_q;
	logic        fpat_q;
	logic        str_q;
	logic        pol_q;
	logic        zacc_q;
	logic        dz_q;
	logic [1:0]  dly_q;
	logic [8:0]  lost;
	logic [8:0]  mon_sig;
	logic [8:0]  mon_tick;
	logic [15:0] mon_lim [9];
	logic [1:0]  mode;
	logic [1:0]  mode_q;
	logic [4:0]  nch;
	logic        int_tick;
	logic        src_tick;
	logic        sel_tick;
	logic        bit_tick;
	logic [2:0]  nbit;
	logic [4:0]  nchan;
	logic        nfbit;
	logic [7:0]  vw;
	logic        dbit;
	logic        sbit;
	logic        obit;
	logic        zs_path;

	assign mode     = ctrl_q[tdmtx_pkg::CTRL_MODE +: 2];
	// The counter adopts a new mode only at the framing slot, so a count never outruns it.
	assign nch      = tdmtx_pkg::nchan(mode_q); // [R11]
	assign int_tick = int_cnt_q == 4'(tdmtx_pkg::INT_DIV_CYC - 1);
	assign src_tick = (src_q == tdmtx_pkg::SRC_EXT) ? (ext_clk & ~ext_d_q) : int_tick; // [R12]
	assign sel_tick = src_tick && ((div_q & tdmtx_pkg::rate_mask(mode))
		== tdmtx_pkg::rate_mask(mode)); // [R13]
	// Data changes as the stream clock falls so the far end samples mid bit.
	assign bit_tick = sel_tick && sclk_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tdmtx_pkg::RESP_OKAY;
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			ctrl_q        <= tdmtx_pkg::CTRL_RST;
			limit_q       <= tdmtx_pkg::LIMIT_RST;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_q      <= s_axi_awaddr;
				aw_full_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_full_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_full_q && w_full_q && !s_axi_bvalid)
			begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= tdmtx_pkg::RESP_OKAY;
				case (awaddr_q)
					tdmtx_pkg::ADDR_CTRL:
					begin
						if (wstrb_q[0])
						begin
							ctrl_q <= wdata_q[7:0]; // [R14]
						end
					end
					tdmtx_pkg::ADDR_LIMIT:
					begin
						if (wstrb_q[0])
						begin
							limit_q[7:0] <= wdata_q[7:0];
						end
						if (wstrb_q[1])
						begin
							limit_q[15:8] <= wdata_q[15:8];
						end
					end
					tdmtx_pkg::ADDR_STAT: s_axi_bresp <= tdmtx_pkg::RESP_OKAY;
					default: s_axi_bresp <= tdmtx_pkg::RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= tdmtx_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= tdmtx_pkg::RESP_OKAY;
			case (s_axi_araddr)
				tdmtx_pkg::ADDR_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
				tdmtx_pkg::ADDR_LIMIT: s_axi_rdata <= {16'h0000, limit_q};
				tdmtx_pkg::ADDR_STAT: s_axi_rdata <= {16'h0000, bit_q, chan_q,
					2'h0, src_q, lost[8], out_alarm_q, loss_output_q, fault_alarm_q};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= tdmtx_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// A short lock wait keeps a flickering external input from stealing the source.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_q  <= tdmtx_pkg::SRC_INT;
			lock_q <= 12'h000;
		end
		else if (lost[8])
		begin
			src_q  <= tdmtx_pkg::SRC_INT; // [R12]
			lock_q <= 12'h000;
		end
		else
		begin
			case (src_q)
				tdmtx_pkg::SRC_INT: src_q <= tdmtx_pkg::SRC_LOCK;
				tdmtx_pkg::SRC_LOCK:
				begin
					lock_q <= lock_q + 12'h001;
					if (lock_q == 12'(tdmtx_pkg::LOCK_CYC - 1))
					begin
						src_q <= tdmtx_pkg::SRC_EXT;
					end
				end
				tdmtx_pkg::SRC_EXT: src_q <= tdmtx_pkg::SRC_EXT;
				default: src_q <= tdmtx_pkg::SRC_INT;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_cnt_q    <= 4'h0;
			ext_d_q      <= 1'b0;
			div_q        <= 3'h0;
			sclk_q       <= 1'b0;
			nrz_clk_q    <= 1'b0;
			master_clk_q <= 1'b0;
		end
		else
		begin
			ext_d_q   <= ext_clk;
			int_cnt_q <= int_tick ? 4'h0 : int_cnt_q + 4'h1;
			if (src_tick)
			begin
				div_q <= div_q + 3'h1; // [R13]
			end
			if (sel_tick)
			begin
				sclk_q       <= ~sclk_q;
				nrz_clk_q    <= ~sclk_q; // [R20]
				master_clk_q <= ~sclk_q; // [R20]
			end
		end
	end

	always_comb
	begin
		nfbit = 1'b0;
		nbit  = bit_q + 3'h1;
		nchan = chan_q;
		if (fbit_q)
		begin
			nbit  = 3'h0; // [R10]
			nchan = 5'h00;
		end
		else if (bit_q == 3'h7)
		begin
			if (chan_q == nch - 5'h01)
			begin
				nfbit = 1'b1; // [R8]
				nchan = 5'h00;
			end
			else
			begin
				nchan = chan_q + 5'h01;
			end
		end
	end

	assign zs_path = ctrl_q[tdmtx_pkg::CTRL_ZS] && ctrl_q[tdmtx_pkg::CTRL_BIPOLAR]
		&& mode == tdmtx_pkg::MODE_24CH;

	always_comb
	begin
		vw = pcm_word;
		if (ctrl_q[tdmtx_pkg::CTRL_TONE])
		begin
			vw = tdmtx_pkg::tone_word(tone_q); // [R1]
		end
		else if (zs_path && dz_q && pcm_word[7:2] == 6'h00)
		begin
			vw[1] = 1'b1; // [R21]
		end
		else if (ctrl_q[tdmtx_pkg::CTRL_VARIANT] && pcm_word[7:1] == 7'h00)
		begin
			vw[1] = 1'b1; // [R6]
		end
	end

	assign dbit = (alarm_in && ctrl_q[tdmtx_pkg::CTRL_FULLALM])
		? tdmtx_pkg::ALARM_PAT[3'h7 - nbit] : dly_q[0]; // [R23]
	assign sbit = nfbit ? tdmtx_pkg::FRAME_PAT[fpos_q]
		: (dly_q[1] ? dbit : vw[3'h7 - nbit]); // [R2] [R3]
	assign obit = ctrl_q[tdmtx_pkg::CTRL_LOOP] ? loop_data : sbit; // [R17]

	tdmtx_dly_mem u_dly (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (bit_tick),
		.wdata   ({data_enable, dig_data}),
		.rdata_q (dly_q)
	); // [R22]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bit_q        <= 3'h0;
			chan_q       <= 5'h00;
			mode_q       <= tdmtx_pkg::CTRL_RST[1:0];
			fbit_q       <= 1'b1;
			chan_count_q <= 5'h00;
			chan_sel_q   <= 24'h000000;
			frame_sync_q <= 1'b0;
			power_sync_q <= 1'b0;
		end
		else
		begin
			frame_sync_q <= bit_tick && nfbit; // [R4]
			if (bit_tick)
			begin
				bit_q        <= nbit; // [R7]
				chan_q       <= nchan;
				fbit_q       <= nfbit;
				if (nfbit)
				begin
					mode_q <= mode; // [R11]
				end
				chan_count_q <= nchan; // [R7]
				for (int i = 0; i < tdmtx_pkg::NUM_CH; i++)
				begin
					chan_sel_q[i] <= !nfbit && nchan == 5'(i); // [R9]
				end
				power_sync_q <= (fbit_q || (nbit == 3'h0 && nchan == (nch >> 1))); // [R16]
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fpos_q <= 4'h0;
			tone_q <= 3'h0;
			fpat_q <= 1'b0;
		end
		else if (bit_tick && nfbit)
		begin
			fpat_q <= tdmtx_pkg::FRAME_PAT[fpos_q]; // [R4]
			fpos_q <= (fpos_q == tdmtx_pkg::FRAME_LEN - 4'h1) ? 4'h0 : fpos_q + 4'h1;
			tone_q <= tone_q + 3'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			zacc_q <= 1'b0;
			dz_q   <= 1'b0;
		end
		else if (bit_tick && !nfbit)
		begin
			if (dly_q[1])
			begin
				zacc_q <= (nbit == 3'h0 ? 1'b1 : zacc_q) & ~dly_q[0];
				if (nbit == 3'h7)
				begin
					dz_q <= zacc_q & ~dly_q[0]; // [R21]
				end
			end
			else if (nbit == 3'h7)
			begin
				dz_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			str_q      <= 1'b0;
			line_nrz_q <= 1'b0;
			line_pos_q <= 1'b0;
			line_neg_q <= 1'b0;
			pol_q      <= 1'b0;
		end
		else if (bit_tick)
		begin
			str_q      <= sbit;
			line_nrz_q <= obit; // [R18]
			if (ctrl_q[tdmtx_pkg::CTRL_BIPOLAR])
			begin
				line_pos_q <= obit & ~pol_q; // [R25]
				line_neg_q <= obit & pol_q;
				pol_q      <= pol_q ^ obit;
			end
			else
			begin
				line_pos_q <= 1'b0;
				line_neg_q <= 1'b0;
			end
		end
	end

	assign mon_sig  = {ext_clk, nrz_clk_q, line_nrz_q, power_sync_q, sclk_q, div_q[0],
		str_q, fbit_q, fpat_q};
	assign mon_tick = {1'b1, 1'b1, bit_tick, bit_tick, 1'b1, 1'b1, bit_tick, bit_tick, bit_tick};

	generate
		for (genvar g = 0; g < 9; g++)
		begin : g_mon
			assign mon_lim[g] = (g == 8) ? 16'(tdmtx_pkg::EXT_LOSS_CYC)
				: (g == 3 || g == 4 || g == 7) ? 16'(tdmtx_pkg::CLK_LOSS_CYC) : limit_q;
			tdmtx_act_mon u_mon (
				.aclk    (aclk),
				.aresetn (aresetn),
				.tick    (mon_tick[g]),
				.sig     (mon_sig[g]),
				.limit   (mon_lim[g]),
				.lost_q  (lost[g])
			);
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fault_alarm_q <= 1'b0;
			loss_output_q <= 1'b0;
			out_alarm_q   <= 1'b0;
		end
		else
		begin
			fault_alarm_q <= |lost[2:0]; // [R5]
			loss_output_q <= |lost[5:3]; // [R15]
			out_alarm_q   <= |lost[7:6]; // [R19]
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	loop_data_a: assert property (bit_tick && ctrl_q[5] |=> line_nrz_q == $past(loop_data)) // [R17]
		else $error("loopback data not on line");
	frame_sync_a: assert property (bit_tick && nfbit |=> frame_sync_q ##1 !frame_sync_q) // [R4]
		else $error("frame sync pulse wrong");
	chan_sel_a: assert property ($onehot0(chan_sel_q) && (fbit_q -> chan_sel_q == 24'h000000)) // [R9]
		else $error("channel select not one-hot");
	restart_a: assert property (bit_tick && fbit_q |=> chan_q == 5'h00 && bit_q == 3'h0) // [R10]
		else $error("counter did not restart at channel 1");
	chan_limit_a: assert property (chan_q < nch) // [R11]
		else $error("channel count beyond mode");
	variant_a: assert property (bit_tick && !nfbit && !dly_q[1] && nbit == 3'h6
		&& ctrl_q[6] && !ctrl_q[7] && pcm_word[7:1] == 7'h00 |=> str_q) // [R6]
		else $error("variant zero suppression missing");
	src_fall_a: assert property (lost[8] |=> src_q == tdmtx_pkg::SRC_INT) // [R12]
		else $error("source not internal after loss");
	fault_a: assert property (lost[2] |=> fault_alarm_q) // [R5]
		else $error("fault alarm not raised");
	ami_a: assert property (bit_tick && ctrl_q[2] && obit |=> line_pos_q != line_neg_q
		&& pol_q != $past(pol_q)) // [R25]
		else $error("bipolar mark wrong");
	psync_a: assert property (bit_tick && fbit_q |=> power_sync_q) // [R16]
		else $error("power sync not at channel 1");

	loop_c: cover property (ctrl_q[5] && bit_tick);
	ext_c: cover property (src_q == tdmtx_pkg::SRC_EXT);
	frame24_c: cover property (mode == tdmtx_pkg::MODE_24CH && bit_tick && fbit_q);
	zs_c: cover property (zs_path && dz_q && bit_tick);
endmodule : tdmtx_mux
`default_nettype wire

// ---- sim/tdmtx_far_end.sv ----
`default_nettype none
// Far-end line receiver: samples the stream on the rising edge of the line clock.
module tdmtx_far_end (
	input  wire logic        line_clk,
	input  wire logic        clr,
	input  wire logic        line_nrz,
	input  wire logic        line_pos,
	input  wire logic        line_neg,
	output logic      [15:0] bits_q,
	output logic      [7:0]  cnt_q,
	output logic      [7:0]  marks_q,
	output logic             ami_err_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_pos_q;
	logic seen_q;

	// Data is launched on the falling edge, so the rising edge sees it settled.
	always_ff @(posedge line_clk or posedge clr)
	begin
		if (clr)
		begin
			bits_q     <= 16'h0000;
			cnt_q      <= 8'h00;
			marks_q    <= 8'h00;
			ami_err_q  <= 1'b0;
			last_pos_q <= 1'b0;
			seen_q     <= 1'b0;
		end
		else
		begin
			bits_q <= {bits_q[14:0], line_nrz};
			cnt_q  <= cnt_q + 8'h01;
			// A mark must follow every one, never a zero, and must alternate.
			if ((line_pos & line_neg) || ((line_pos | line_neg) !== line_nrz))
				ami_err_q <= 1'b1;
			if (line_pos | line_neg)
			begin
				marks_q <= marks_q + 8'h01;
				if (seen_q && (last_pos_q == line_pos))
					ami_err_q <= 1'b1;
				last_pos_q <= line_pos;
				seen_q     <= 1'b1;
			end
		end
	end
endmodule : tdmtx_far_end
`default_nettype wire

// ---- sim/test_tdm_transmit_multiplexer.sv ----
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_tdm_transmit_multiplexer;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, ext_clk, dig_data, data_enable, alarm_in, loop_data;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [7:0]  pcm_word;
	logic [23:0] chan_sel_q;
	logic [4:0]  chan_count_q;
	logic frame_sync_q, line_nrz_q, line_pos_q, line_neg_q, nrz_clk_q, master_clk_q;
	logic power_sync_q, fault_alarm_q, loss_output_q, out_alarm_q, clr, ami_err;
	logic [15:0] fe_bits;
	logic [7:0]  fe_cnt, fe_marks;
	int err_total = 0;
	int total_checks = 0;

	tdmtx_mux dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_clk(ext_clk), .pcm_word(pcm_word), .dig_data(dig_data),
		.data_enable(data_enable), .alarm_in(alarm_in), .loop_data(loop_data),
		.chan_sel_q(chan_sel_q), .chan_count_q(chan_count_q), .frame_sync_q(frame_sync_q),
		.line_nrz_q(line_nrz_q), .line_pos_q(line_pos_q), .line_neg_q(line_neg_q),
		.nrz_clk_q(nrz_clk_q), .master_clk_q(master_clk_q), .power_sync_q(power_sync_q),
		.fault_alarm_q(fault_alarm_q), .loss_output_q(loss_output_q),
		.out_alarm_q(out_alarm_q));

	tdmtx_far_end far (.line_clk(nrz_clk_q), .clr(clr), .line_nrz(line_nrz_q),
		.line_pos(line_pos_q), .line_neg(line_neg_q), .bits_q(fe_bits), .cnt_q(fe_cnt),
		.marks_q(fe_marks), .ami_err_q(ami_err));

	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic summarize();
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while ((awvalid || wvalid) && n < 100)
		begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			n++;
		end
		do
		begin
			@(posedge aclk);
			n++;
		end while (bvalid !== 1'b1 && n < 200);
		bready <= 1'b0;
		`CHK("bresp", r, bresp)
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
		end while (arready !== 1'b1 && n < 100);
		arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			n++;
		end while (rvalid !== 1'b1 && n < 200);
		rready <= 1'b0;
		`CHK("rresp", r, rresp)
		`CHK("rdata", d, rdata)
	endtask : axi_rd

	task automatic wait_fs();
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end while (frame_sync_q !== 1'b1 && n < 20000);
	endtask : wait_fs

	// Restart the far end just after the frame start and collect nb line bits.
	task automatic grab(input int nb);
		int n;
		n = 0;
		wait_fs();
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		while (fe_cnt < nb && n < 20000)
		begin
			@(posedge aclk);
			n++;
		end
	endtask : grab

	task automatic s_regs();
		axi_rd(tdmtx_pkg::ADDR_CTRL, {24'h000000, tdmtx_pkg::CTRL_RST}, tdmtx_pkg::RESP_OKAY);
		axi_rd(tdmtx_pkg::ADDR_LIMIT, {16'h0000, tdmtx_pkg::LIMIT_RST}, tdmtx_pkg::RESP_OKAY);
		axi_rd(12'h00c, 32'h00000000, tdmtx_pkg::RESP_SLVERR);
		axi_wr(12'h00c, 32'h0000ffff, tdmtx_pkg::RESP_SLVERR);
		axi_wr(tdmtx_pkg::ADDR_LIMIT, 32'h00000010, tdmtx_pkg::RESP_OKAY);
		axi_rd(tdmtx_pkg::ADDR_LIMIT, 32'h00000010, tdmtx_pkg::RESP_OKAY);
	endtask : s_regs

	// Frame length, one-hot slot selects and two power sync pulses per frame.
	task automatic s_frame(input logic [1:0] m);
		int cnt;
		int ps;
		logic bad;
		logic pprev;
		axi_wr(tdmtx_pkg::ADDR_CTRL, {30'h0, m}, tdmtx_pkg::RESP_OKAY);
		wait_fs();
		wait_fs();
		cnt = 0;
		ps = 0;
		bad = 1'b0;
		pprev = power_sync_q;
		do
		begin
			@(posedge aclk);
			cnt++;
			if (power_sync_q === 1'b1 && pprev !== 1'b1) ps++;
			pprev = power_sync_q;
			if (!$onehot0(chan_sel_q) || master_clk_q !== nrz_clk_q
				|| chan_count_q >= (5'h03 << m)) bad = 1'b1;
		end while (frame_sync_q !== 1'b1 && cnt < 20000);
		`CHK("frame period", (1 + (24 << m)) * (16 << (3 - m)), cnt)
		`CHK("power sync", 2, ps)
		`CHK("slot select", 1'b0, bad)
	endtask : s_frame

	// Channel 1 voice word follows the framing bit, most significant bit first.
	task automatic s_voice();
		axi_wr(tdmtx_pkg::ADDR_CTRL, 32'h00000003, tdmtx_pkg::RESP_OKAY);
		pcm_word <= 8'ha5;
		grab(9);
		`CHK("voice word", 8'ha5, fe_bits[7:0])
	endtask : s_voice

	task automatic s_bipolar();
		axi_wr(tdmtx_pkg::ADDR_CTRL, 32'h00000007, tdmtx_pkg::RESP_OKAY);
		pcm_word <= 8'hff;
		grab(40);
		`CHK("ami error", 1'b0, ami_err)
		`CHK("marks seen", 1'b1, fe_marks > 8'h10)
	endtask : s_bipolar

	// Loop data held at one stops output activity, which must raise and then clear the alarm.
	task automatic s_loop();
		int n;
		n = 0;
		pcm_word <= 8'ha5;
		axi_wr(tdmtx_pkg::ADDR_CTRL, 32'h00000003, tdmtx_pkg::RESP_OKAY);
		while (out_alarm_q !== 1'b0 && n < 2000)
		begin
			@(posedge aclk);
			n++;
		end
		`CHK("alarm idle", 1'b0, out_alarm_q)
		loop_data <= 1'b1;
		axi_wr(tdmtx_pkg::ADDR_CTRL, 32'h00000023, tdmtx_pkg::RESP_OKAY);
		n = 0;
		while (out_alarm_q !== 1'b1 && n < 1000)
		begin
			@(posedge aclk);
			n++;
		end
		`CHK("alarm set", 1'b1, out_alarm_q)
		`CHK("alarm delay", 1'b1, n >= 13 * 16)
		grab(16);
		`CHK("loop bits", 16'hffff, fe_bits)
		axi_wr(tdmtx_pkg::ADDR_CTRL, 32'h00000003, tdmtx_pkg::RESP_OKAY);
		n = 0;
		while (out_alarm_q !== 1'b0 && n < 1000)
		begin
			@(posedge aclk);
			n++;
		end
		`CHK("alarm clear", 1'b0, out_alarm_q)
	endtask : s_loop

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h00;
		{ext_clk, dig_data, data_enable, alarm_in, loop_data} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		pcm_word = 8'h00;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		s_regs();
		for (int m = 3; m >= 0; m--)
			s_frame(m[1:0]);
		s_voice();
		s_bipolar();
		s_loop();
		summarize();
	end

	initial
	begin
		repeat (100000) @(posedge aclk);
		err_total++;
		summarize();
	end
endmodule : test_tdm_transmit_multiplexer
`default_nettype wire
